//--- rtl/fmc_pkg.sv
// Purpose: shared constants and types of the four-bit controller datapath
// Assumes: one instruction cycle spans CYCLE_DIV_DEFAULT cycles of mclk
// Notes:   ops arrive already decoded; instruction encodings live outside this block
package fmc_pkg;

   // instruction cycle timing
   localparam int CYCLE_DIV_DEFAULT   = 4;
   localparam int RESET_HOLD_CYCLES   = 3;
   localparam int SI_MIN_PULSE_CYCLES = 2;

   // program store and data memory geometry
   localparam int PROG_WORDS  = 512;
   localparam int PAGE_WORDS  = 64;
   localparam int PROG_PAGES  = 8;
   localparam int RAM_ROWS    = 4;
   localparam int RAM_DIGITS  = 8;
   localparam int RAM_WORDS   = RAM_ROWS * RAM_DIGITS;

   // feature_enable bit positions
   localparam int EN_COUNTER_BIT    = 0;
   localparam int EN_UNUSED_BIT     = 1;
   localparam int EN_PORT_DRIVE_BIT = 2;
   localparam int EN_SERIAL_OUT_BIT = 3;

   // values after reset
   localparam logic [8:0] PC_RESET     = 9'h000;
   localparam logic [3:0] ENABLE_RESET = 4'h0;
   localparam logic       SKL_RESET    = 1'h1;

   // digit pointer values whose crossing makes a skip
   localparam logic [3:0] DIGIT_PTR_MAX = 4'hF;
   localparam logic [3:0] DIGIT_PTR_MIN = 4'h0;

   typedef enum logic [4:0] {
      OP_NOP,
      OP_CLEAR_ACC,
      OP_ADD_MEM,
      OP_ADD_CARRY,
      OP_ADD_IMM,
      OP_COMPLEMENT,
      OP_SET_CARRY,
      OP_RESET_CARRY,
      OP_LOAD_MEM,
      OP_EXCHANGE,
      OP_EXCH_INC_SKIP,
      OP_EXCH_DEC_SKIP,
      OP_STORE_IMM_INC,
      OP_LOAD_POINTER,
      OP_ACC_TO_DIGIT,
      OP_DIGIT_TO_ACC,
      OP_ACC_MEM_TO_LATCH,
      OP_LOAD_LATCH_TABLE,
      OP_INPUT_L,
      OP_INPUT_G,
      OP_OUTPUT_G,
      OP_OUTPUT_DIGIT,
      OP_SWAP_ACC_SERIAL,
      OP_LOAD_ENABLE,
      OP_JUMP,
      OP_JUMP_IN_PAGE,
      OP_CALL,
      OP_RETURN
   } fmc_op_t;

endpackage

//--- rtl/fmc_si_sampler.sv
// Purpose: samples the serial input pin on the link clock and reports level and falls
// Assumes: linkClk runs free while counter pulses may arrive
// Notes:   falls cross to mclk as a toggle, the level as a plain two-flop level
`timescale 1ns/1ps
module fmc_si_sampler (
   input  logic linkClk,
   input  logic rst_b,
   input  logic serialInPin,
   output logic siLevel,
   output logic siFallToggle
);

   typedef struct packed {
      logic rstSync1;
      logic rstSync2;
      logic pinSync1;
      logic pinSync2;
      logic pinPrev;
      logic level;
      logic toggle;
   } fmc_sampler_state_t;

   fmc_sampler_state_t q;
   fmc_sampler_state_t d;

   always_comb begin
      d          = q;
      d.rstSync1 = rst_b;
      d.rstSync2 = q.rstSync1;
      if (!q.rstSync2) begin
         d.pinSync1 = 1'h0;
         d.pinSync2 = 1'h0;
         d.pinPrev  = 1'h0;
         d.level    = 1'h0;
         d.toggle   = 1'h0;
      end else begin
         d.pinSync1 = serialInPin;
         d.pinSync2 = q.pinSync1;
         d.pinPrev  = q.pinSync2;
         d.level    = q.pinSync2;
         // one toggle per high-to-low step of the synchronised pin
         if (q.pinPrev && !q.pinSync2) begin
            d.toggle = ~q.toggle;
         end
      end
   end

   always_ff @(posedge linkClk) begin
      q <= d;
   end

   assign siLevel      = q.level;
   assign siFallToggle = q.toggle;

endmodule

//--- rtl/fmc_core.sv
// Purpose: datapath and pin control of a four-bit single-chip controller
// Assumes: an outside decoder presents one op per instruction cycle on opSel/opImm
// Notes:   rst_b is synchronous; data memory survives it
//
// What this block does
// - program store of 512 bytes, viewed as 8 pages of 64 words
// - program counter loads every cycle, plus one unless control transfers
// - calls push return address onto two-deep save stack
// - data memory 4 rows of 8 digits, row and low digit bits select
// - top digit pointer bit ignored when selecting memory
// - exchange-step ops skip on pointer wrap 15/0, not on 7/8
// - digit pointer is the source for the digit output port
// - 4-bit adder writes accumulator and carry register
// - accumulator loads pointer, G input, L input, swaps with serial register
// - general-purpose register drives its four pins continuously
// - output latch loads from memory with accumulator or program data
// - L pin levels readable into accumulator and memory digit
// - accumulator-serial swap copies carry into serial clock latch
// - enable register written only by load-enable op, one feature per bit except bit 1
// - enable bit 0 set: serial register counts down on input falls
// - counter mode: clock pin shows latch, serial output shows enable bit 3
// - enable bit 0 clear: serial register shifts left, input into bit 0
// - shift mode: clock pin is latch ANDed with instruction clock
// - shift mode: output is serial MSB with bit 3 set, else 0
// - enable bit 2 drives L pins from latch, else pins float
// - enable bit 1 affects nothing
// - reset clears counter, accumulator, pointer, carry, enables, and all outputs but progData (word 0), gPinOe and the clock pin, held high; memory kept
// - after reset the clock pin pulses once each instruction cycle
`timescale 1ns/1ps
module fmc_core #(
   parameter int CYCLE_DIV = fmc_pkg::CYCLE_DIV_DEFAULT
) (
   input  logic            mclk,
   input  logic            rst_b,
   input  logic            linkClk,
   input  fmc_pkg::fmc_op_t opSel,
   input  logic [8:0]      opImm,
   input  logic            progWrEn,
   input  logic [8:0]      progWrAddr,
   input  logic [7:0]      progWrData,
   output logic            cycleStrobe,
   output logic [8:0]      progAddr,
   output logic [7:0]      progData,
   output logic            skipNext,
   input  logic [7:0]      lPinIn,
   output logic [7:0]      lPinOut,
   output logic [7:0]      lPinOe,
   input  logic [3:0]      gPinIn,
   output logic [3:0]      gPinOut,
   output logic [3:0]      gPinOe,
   output logic [3:0]      digitOut,
   input  logic            serialInPin,
   output logic            serialOutPin,
   output logic            serialClockPin
);

   localparam int PHASE_W = (CYCLE_DIV > 2) ? $clog2(CYCLE_DIV) : 1;
   localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(CYCLE_DIV - 1);
   localparam logic [PHASE_W-1:0] PHASE_HALF = PHASE_W'(CYCLE_DIV / 2);
   localparam logic [PHASE_W-1:0] PHASE_ONE  = PHASE_W'(1);

   if (CYCLE_DIV < 2) begin : g_div_check
      $error("CYCLE_DIV must be at least 2");
   end

   // pc is nine bits wide and its top three bits name the page
   if (fmc_pkg::PROG_WORDS != 512 ||
       fmc_pkg::PAGE_WORDS * fmc_pkg::PROG_PAGES != fmc_pkg::PROG_WORDS) begin : g_page_check
      $error("program pages must tile a 512 word store");
   end

   // ramIndex packs a row and three digit bits into five
   if (fmc_pkg::RAM_ROWS != 4 || fmc_pkg::RAM_DIGITS != 8) begin : g_ram_check
      $error("data memory must be 4 rows of 8 digits");
   end

   typedef struct packed {
      logic [fmc_pkg::PROG_WORDS-1:0][7:0] prog;
      logic [fmc_pkg::RAM_WORDS-1:0][3:0]  ram;
      logic [8:0]         pc;
      logic [8:0]         saveFirst;
      logic [8:0]         saveSecond;
      logic [3:0]         acc;
      logic               carry;
      logic [1:0]         rowSelect;
      logic [3:0]         digitPointer;
      logic [3:0]         digitOut;
      logic [3:0]         gReg;
      logic [7:0]         latchQ;
      logic [3:0]         serialRegister;
      logic               serialClockLatch;
      logic [3:0]         featureEnable;
      logic               skip;
      logic [7:0]         fetched;
      logic [PHASE_W-1:0] phase;
      logic               sk;
      logic               so;
      logic [7:0]         lSync1;
      logic [7:0]         lSync2;
      logic [3:0]         gSync1;
      logic [3:0]         gSync2;
      logic               siSync1;
      logic               siSync2;
      logic               togSync1;
      logic               togSync2;
      logic               togPrev;
      logic               fallPending;
   } fmc_core_state_t;

   fmc_core_state_t q;
   fmc_core_state_t d;

   logic       siLevelLink;
   logic       siToggleLink;
   logic       cycleEn;
   logic       fallEvent;
   logic       instClkHigh;
   logic [4:0] ramIdx;
   logic [3:0] memDigit;
   logic [4:0] sum;
   logic [8:0] tableAddr;

   // top digit pointer bit dropped: two pointer values per physical digit
   function automatic logic [4:0] ramIndex(input logic [1:0] row, input logic [3:0] dig);
      ramIndex = {row, dig[2:0]};
   endfunction

   function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b, input logic cin);
      add4 = {1'h0, a} + {1'h0, b} + {4'h0, cin};
   endfunction

   function automatic logic [8:0] pcNext(input logic [8:0] pc);
      pcNext = pc + 9'h001;
   endfunction

   function automatic logic [3:0] digitStep(input logic [3:0] ptr, input logic down);
      digitStep = down ? ptr - 4'h1 : ptr + 4'h1;
   endfunction

   fmc_si_sampler u_si_sampler (
      .linkClk      (linkClk),
      .rst_b        (rst_b),
      .serialInPin  (serialInPin),
      .siLevel      (siLevelLink),
      .siFallToggle (siToggleLink)
   );

   assign cycleEn   = (q.phase == PHASE_LAST);
   assign fallEvent = q.togSync2 ^ q.togPrev;
   assign ramIdx    = ramIndex(q.rowSelect, q.digitPointer);
   assign memDigit  = q.ram[ramIdx];
   // table words stay inside the current page
   assign tableAddr = {q.pc[8:6], q.acc[1:0], memDigit};

   always_comb begin
      d           = q;
      sum         = 5'h00;
      instClkHigh = 1'h0;
      if (!rst_b) begin
         d                  = '0;
         d.prog             = q.prog;
         d.ram              = q.ram;
         d.pc               = fmc_pkg::PC_RESET;
         d.featureEnable    = fmc_pkg::ENABLE_RESET;
         d.serialClockLatch = fmc_pkg::SKL_RESET;
         d.fetched          = q.prog[fmc_pkg::PC_RESET];
      end else begin
         // all four crossings land in the second stage before anyone looks
         d.lSync1   = lPinIn;
         d.lSync2   = q.lSync1;
         d.gSync1   = gPinIn;
         d.gSync2   = q.gSync1;
         d.siSync1  = siLevelLink;
         d.siSync2  = q.siSync1;
         d.togSync1 = siToggleLink;
         d.togSync2 = q.togSync1;
         d.togPrev  = q.togSync2;
         d.fallPending = q.fallPending | fallEvent;
         d.phase    = cycleEn ? '0 : q.phase + PHASE_ONE;

         if (cycleEn) begin
            d.pc   = pcNext(q.pc);
            d.skip = 1'h0;
            if (progWrEn) begin
               d.prog[progWrAddr] = progWrData;
            end

            // a fall seen this very cycle stays pending for the next one
            d.fallPending = fallEvent;
            if (q.featureEnable[fmc_pkg::EN_COUNTER_BIT]) begin
               if (q.fallPending) begin
                  d.serialRegister = q.serialRegister - 4'h1;
               end
            end else begin
               d.serialRegister = {q.serialRegister[2:0], q.siSync2};
            end

            case (opSel)
               fmc_pkg::OP_CLEAR_ACC: begin
                  d.acc = 4'h0;
               end
               fmc_pkg::OP_ADD_MEM: begin
                  sum   = add4(q.acc, memDigit, 1'h0);
                  d.acc = sum[3:0];
               end
               fmc_pkg::OP_ADD_CARRY: begin
                  sum     = add4(q.acc, memDigit, q.carry);
                  d.acc   = sum[3:0];
                  d.carry = sum[4];
                  d.skip  = sum[4];
               end
               fmc_pkg::OP_ADD_IMM: begin
                  sum    = add4(q.acc, opImm[3:0], 1'h0);
                  d.acc  = sum[3:0];
                  d.skip = sum[4];
               end
               fmc_pkg::OP_COMPLEMENT: begin
                  d.acc = ~q.acc;
               end
               fmc_pkg::OP_SET_CARRY: begin
                  d.carry = 1'h1;
               end
               fmc_pkg::OP_RESET_CARRY: begin
                  d.carry = 1'h0;
               end
               fmc_pkg::OP_LOAD_MEM: begin
                  d.acc = memDigit;
               end
               fmc_pkg::OP_EXCHANGE: begin
                  d.acc         = memDigit;
                  d.ram[ramIdx] = q.acc;
               end
               fmc_pkg::OP_EXCH_INC_SKIP: begin
                  d.acc          = memDigit;
                  d.ram[ramIdx]  = q.acc;
                  d.digitPointer = digitStep(q.digitPointer, 1'h0);
                  // 7 to 8 is an ordinary step, only 15 to 0 skips
                  d.skip         = (q.digitPointer == fmc_pkg::DIGIT_PTR_MAX);
               end
               fmc_pkg::OP_EXCH_DEC_SKIP: begin
                  d.acc          = memDigit;
                  d.ram[ramIdx]  = q.acc;
                  d.digitPointer = digitStep(q.digitPointer, 1'h1);
                  d.skip         = (q.digitPointer == fmc_pkg::DIGIT_PTR_MIN);
               end
               fmc_pkg::OP_STORE_IMM_INC: begin
                  d.ram[ramIdx]  = opImm[3:0];
                  d.digitPointer = digitStep(q.digitPointer, 1'h0);
               end
               fmc_pkg::OP_LOAD_POINTER: begin
                  d.rowSelect    = opImm[5:4];
                  d.digitPointer = opImm[3:0];
               end
               fmc_pkg::OP_ACC_TO_DIGIT: begin
                  d.digitPointer = q.acc;
               end
               fmc_pkg::OP_DIGIT_TO_ACC: begin
                  d.acc = q.digitPointer;
               end
               fmc_pkg::OP_ACC_MEM_TO_LATCH: begin
                  d.latchQ = {q.acc, memDigit};
               end
               fmc_pkg::OP_LOAD_LATCH_TABLE: begin
                  d.latchQ = q.prog[tableAddr];
               end
               fmc_pkg::OP_INPUT_L: begin
                  d.acc         = q.lSync2[3:0];
                  d.ram[ramIdx] = q.lSync2[7:4];
               end
               fmc_pkg::OP_INPUT_G: begin
                  d.acc = q.gSync2;
               end
               fmc_pkg::OP_OUTPUT_G: begin
                  d.gReg = memDigit;
               end
               fmc_pkg::OP_OUTPUT_DIGIT: begin
                  d.digitOut = q.digitPointer;
               end
               fmc_pkg::OP_SWAP_ACC_SERIAL: begin
                  // swap wins over this cycle's shift or count
                  // a fall pending at this edge is lost, one arriving on it is kept
                  d.acc              = q.serialRegister;
                  d.serialRegister   = q.acc;
                  d.serialClockLatch = q.carry;
               end
               fmc_pkg::OP_LOAD_ENABLE: begin
                  d.featureEnable = opImm[3:0];
               end
               fmc_pkg::OP_JUMP: begin
                  d.pc = opImm;
               end
               fmc_pkg::OP_JUMP_IN_PAGE: begin
                  d.pc = {q.pc[8:6], opImm[5:0]};
               end
               fmc_pkg::OP_CALL: begin
                  // a third nested call loses the oldest return address
                  d.saveSecond = q.saveFirst;
                  d.saveFirst  = pcNext(q.pc);
                  d.pc         = opImm;
               end
               fmc_pkg::OP_RETURN: begin
                  d.pc        = q.saveFirst;
                  d.saveFirst = q.saveSecond;
               end
               default: begin
               end
            endcase
            d.fetched = d.prog[d.pc];
         end
      end

      // pins registered from next-state values so they move with the cycle
      instClkHigh = (d.phase < PHASE_HALF);
      if (d.featureEnable[fmc_pkg::EN_COUNTER_BIT]) begin
         d.sk = d.serialClockLatch;
         d.so = d.featureEnable[fmc_pkg::EN_SERIAL_OUT_BIT];
      end else begin
         d.sk = d.serialClockLatch & instClkHigh;
         d.so = d.featureEnable[fmc_pkg::EN_SERIAL_OUT_BIT] & d.serialRegister[3];
      end
   end

   always_ff @(posedge mclk) begin
      q <= d;
   end

   assign cycleStrobe    = cycleEn & rst_b;
   assign progAddr       = q.pc;
   assign progData       = q.fetched;
   assign skipNext       = q.skip;
   assign lPinOut        = q.latchQ;
   // bit 1 of the enable register is never read
   assign lPinOe         = {8{q.featureEnable[fmc_pkg::EN_PORT_DRIVE_BIT]}};
   assign gPinOut        = q.gReg;
   assign gPinOe         = 4'hF;
   assign digitOut       = q.digitOut;
   assign serialOutPin   = q.so;
   assign serialClockPin = q.sk;

endmodule

//--- test/fmc_core_properties.sv
// Purpose: pin-level checks on the controller core
// Assumes: bound instance runs with CYCLE_DIV of 4
// Notes:   enable value is shadowed from load-enable ops
`timescale 1ns/1ps
module fmc_core_properties (
   input logic             mclk,
   input logic             rst_b,
   input fmc_pkg::fmc_op_t opSel,
   input logic [8:0]       opImm,
   input logic             cycleStrobe,
   input logic [8:0]       progAddr,
   input logic [7:0]       lPinOe,
   input logic [7:0]       lPinOut,
   input logic [3:0]       gPinOe,
   input logic [3:0]       gPinOut,
   input logic [3:0]       digitOut,
   input logic             serialOutPin,
   input logic             serialClockPin
);
   logic [3:0] enShadow_q;
   logic       ldEn;
   logic       xfer;
   assign ldEn = cycleStrobe && opSel == fmc_pkg::OP_LOAD_ENABLE;
   assign xfer = opSel inside {fmc_pkg::OP_JUMP, fmc_pkg::OP_JUMP_IN_PAGE, fmc_pkg::OP_CALL,
                               fmc_pkg::OP_RETURN, fmc_pkg::OP_LOAD_LATCH_TABLE};
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         enShadow_q <= 4'h0;
      end else if (ldEn) begin
         enShadow_q <= opImm[3:0];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_strobe_period: assert property (
      cycleStrobe |=> !cycleStrobe [*3] ##1 cycleStrobe) else $error("strobe spacing wrong");
   a_pc_step: assert property (
      cycleStrobe && !xfer |=> progAddr == $past(progAddr) + 9'h001) else $error("pc did not step");
   a_jump_target: assert property (
      cycleStrobe && opSel == fmc_pkg::OP_JUMP |=> progAddr == $past(opImm)) else $error("jump missed");
   a_gpin_drive: assert property (
      gPinOe == 4'hF) else $error("g pins not driven");
   a_enable_drive: assert property (
      ldEn |=> lPinOe == {8{enShadow_q[2]}}) else $error("l drive enable wrong");
   a_enable_hold: assert property (
      !ldEn |=> $stable(lPinOe)) else $error("l enable moved");
   a_digit_hold: assert property (
      !(cycleStrobe && opSel == fmc_pkg::OP_OUTPUT_DIGIT) |=> $stable(digitOut)) else $error("digit moved");
   a_count_so: assert property (
      enShadow_q[0] && $stable(enShadow_q) |-> serialOutPin == enShadow_q[3]) else $error("counter so");
   a_shift_so_off: assert property (
      !enShadow_q[0] && !enShadow_q[3] && $stable(enShadow_q) |-> !serialOutPin) else $error("so not 0");
   a_sync_pulse: assert property (
      !enShadow_q[0] && $rose(serialClockPin) |-> serialClockPin [*2] ##1 !serialClockPin)
      else $error("clock pulse shape");
   a_latch_hold: assert property (
      !(cycleStrobe && opSel inside {fmc_pkg::OP_ACC_MEM_TO_LATCH, fmc_pkg::OP_LOAD_LATCH_TABLE})
      |=> $stable(lPinOut)) else $error("latch moved");
   a_gport_hold: assert property (
      !(cycleStrobe && opSel == fmc_pkg::OP_OUTPUT_G) |=> $stable(gPinOut)) else $error("g register moved");
endmodule
bind fmc_core fmc_core_properties i_props (.mclk(mclk), .rst_b(rst_b), .opSel(opSel), .opImm(opImm),
   .cycleStrobe(cycleStrobe), .progAddr(progAddr), .lPinOe(lPinOe), .gPinOe(gPinOe), .digitOut(digitOut),
   .serialOutPin(serialOutPin), .serialClockPin(serialClockPin), .lPinOut(lPinOut), .gPinOut(gPinOut));

//--- test/fmc_periph.sv
// Purpose: peripheral on the L port and the serial input
// Assumes: cycleStrobe marks each instruction cycle
// Notes:   pulses are timed in instruction cycles
`timescale 1ns/1ps
module fmc_periph #(
   parameter int HOLD_CYCLES = 20,
   parameter int PULSES      = 2
) (
   input  logic       mclk,
   input  logic       cycleStrobe,
   input  logic       pulseGo,
   input  logic       siHold,
   input  logic [7:0] lPinOut,
   input  logic [7:0] lPinOe,
   input  logic [7:0] lDrive,
   output logic [7:0] lWire,
   output logic       serialIn,
   output logic       pulseBusy
);
   logic [7:0] phaseLeft = 8'h00;
   int         holdCnt   = 0;
   // peripheral drives only bits the core released
   assign lWire     = (lPinOe & lPinOut) | (~lPinOe & lDrive);
   assign serialIn  = (phaseLeft != 8'h00) ? phaseLeft[0] : siHold;
   assign pulseBusy = phaseLeft != 8'h00;
   always @(posedge mclk) begin
      if (pulseGo) begin
         phaseLeft <= 8'(2 * PULSES);
         holdCnt   <= 0;
      end else if (cycleStrobe && pulseBusy) begin
         if (holdCnt == HOLD_CYCLES - 1) begin
            holdCnt   <= 0;
            phaseLeft <= phaseLeft - 8'h01;
         end else begin
            holdCnt <= holdCnt + 1;
         end
      end
   end
endmodule

//--- test/testbench.sv
// Purpose: op-sequence tests of the controller core
// Assumes: default CYCLE_DIV of 4
// Notes:   acc and memory are seen through the output latch
`timescale 1ns/1ps
module testbench;
   logic             mclk = 1'b0;
   logic             linkClk = 1'b0;
   logic             rst_b = 1'b0;
   fmc_pkg::fmc_op_t opSel = fmc_pkg::OP_NOP;
   logic [8:0]       opImm = 9'h000;
   logic             progWrEn = 1'b0;
   logic [8:0]       progWrAddr = 9'h000;
   logic [7:0]       progWrData = 8'h00;
   logic             siHold = 1'b1;
   logic             pulseGo = 1'b0;
   logic             cycleStrobe, skipNext, serialInPin, serialOutPin, serialClockPin, pulseBusy;
   logic [8:0]       progAddr;
   logic [7:0]       progData, lPinOut, lPinOe, lWire;
   logic [3:0]       gPinOut, gPinOe, digitOut, gWire;
   int               err_total = 0;
   int               checks = 0;
   fmc_pkg::fmc_op_t stOp[4] = '{fmc_pkg::OP_CALL, fmc_pkg::OP_CALL, fmc_pkg::OP_RETURN, fmc_pkg::OP_RETURN};
   logic [8:0]       stImm[4] = '{9'h100, 9'h180, 9'h000, 9'h000};
   logic [8:0]       stExp[4] = '{9'h100, 9'h180, 9'h101, 9'h046};
   fmc_pkg::fmc_op_t skOp[4] = '{fmc_pkg::OP_EXCH_INC_SKIP, fmc_pkg::OP_EXCH_INC_SKIP,
                                 fmc_pkg::OP_EXCH_DEC_SKIP, fmc_pkg::OP_EXCH_DEC_SKIP};
   logic [8:0]       skPtr[4] = '{9'h01F, 9'h017, 9'h010, 9'h018};
   logic             skExp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   always #4 mclk = ~mclk;
   // phase offset keeps link edges off the main clock edges
   initial #3 forever #80 linkClk = ~linkClk;
   assign gWire = (gPinOe & gPinOut) | (~gPinOe & 4'hA);
   fmc_core i_dut (.mclk(mclk), .rst_b(rst_b), .linkClk(linkClk), .opSel(opSel), .opImm(opImm),
      .progWrEn(progWrEn), .progWrAddr(progWrAddr), .progWrData(progWrData), .cycleStrobe(cycleStrobe),
      .progAddr(progAddr), .progData(progData), .skipNext(skipNext), .lPinIn(lWire), .lPinOut(lPinOut),
      .lPinOe(lPinOe), .gPinIn(gWire), .gPinOut(gPinOut), .gPinOe(gPinOe), .digitOut(digitOut),
      .serialInPin(serialInPin), .serialOutPin(serialOutPin), .serialClockPin(serialClockPin));
   fmc_periph i_periph (.mclk(mclk), .cycleStrobe(cycleStrobe), .pulseGo(pulseGo), .siHold(siHold),
      .lPinOut(lPinOut), .lPinOe(lPinOe), .lDrive(8'h3C), .lWire(lWire), .serialIn(serialInPin),
      .pulseBusy(pulseBusy));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic op(input fmc_pkg::fmc_op_t o, input logic [8:0] i = 9'h000,
                     input logic [7:0] d = 8'h00, input logic w = 1'b0);
      @(posedge mclk);
      opSel      <= o;
      opImm      <= i;
      progWrAddr <= i;
      progWrData <= d;
      progWrEn   <= w;
      do @(negedge mclk); while (cycleStrobe !== 1'b1);
      @(negedge mclk);
   endtask
   task automatic nops(input int n);
      repeat (n) op(fmc_pkg::OP_NOP);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      // long enough for three link clock edges
      repeat (64) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk(progAddr, 9'h000);
      chk(digitOut, 4'h0);
      chk(lPinOe, 8'h00);
      chk(serialOutPin, 1'b0);
      op(fmc_pkg::OP_CLEAR_ACC);
      chk(progAddr, 9'h001);
      op(fmc_pkg::OP_NOP, 9'h045, 8'hA5, 1'b1);
      op(fmc_pkg::OP_JUMP, 9'h045);
      chk(progAddr, 9'h045);
      chk(progData, 8'hA5);
      for (int k = 0; k < 4; k++) begin
         op(stOp[k], stImm[k]);
         chk(progAddr, stExp[k]);
      end
      $display("test program flow done");
      op(fmc_pkg::OP_ADD_IMM, 9'h005);
      op(fmc_pkg::OP_LOAD_POINTER, 9'h025);
      op(fmc_pkg::OP_EXCHANGE);
      op(fmc_pkg::OP_CLEAR_ACC);
      op(fmc_pkg::OP_ADD_IMM, 9'h00A);
      op(fmc_pkg::OP_LOAD_POINTER, 9'h02D);
      op(fmc_pkg::OP_ACC_MEM_TO_LATCH);
      chk(lPinOut, 8'hA5);
      op(fmc_pkg::OP_OUTPUT_DIGIT);
      chk(digitOut, 4'hD);
      op(fmc_pkg::OP_LOAD_ENABLE, 9'h004);
      chk(lPinOe, 8'hFF);
      chk(lWire, 8'hA5);
      op(fmc_pkg::OP_LOAD_ENABLE, 9'h002);
      chk(lPinOe, 8'h00);
      op(fmc_pkg::OP_INPUT_L);
      op(fmc_pkg::OP_ACC_MEM_TO_LATCH);
      chk(lPinOut, 8'hC3);
      $display("test memory and port done");
      op(fmc_pkg::OP_RESET_CARRY);
      op(fmc_pkg::OP_CLEAR_ACC);
      op(fmc_pkg::OP_ADD_IMM, 9'h00F);
      op(fmc_pkg::OP_ADD_CARRY);
      chk(skipNext, 1'b1);
      op(fmc_pkg::OP_ACC_MEM_TO_LATCH);
      chk(lPinOut, 8'h23);
      for (int k = 0; k < 4; k++) begin
         op(fmc_pkg::OP_LOAD_POINTER, skPtr[k]);
         op(skOp[k]);
         chk(skipNext, skExp[k]);
      end
      $display("test adder and skip done");
      op(fmc_pkg::OP_LOAD_ENABLE, 9'h008);
      nops(28);
      chk(serialOutPin, 1'b1);
      @(posedge mclk) siHold <= 1'b0;
      nops(28);
      chk(serialOutPin, 1'b0);
      @(posedge mclk) siHold <= 1'b1;
      nops(28);
      op(fmc_pkg::OP_LOAD_ENABLE, 9'h000);
      op(fmc_pkg::OP_NOP);
      chk(serialOutPin, 1'b0);
      op(fmc_pkg::OP_SWAP_ACC_SERIAL);
      op(fmc_pkg::OP_LOAD_POINTER, 9'h02D);
      op(fmc_pkg::OP_ACC_MEM_TO_LATCH);
      chk(lPinOut, 8'hF3);
      op(fmc_pkg::OP_RESET_CARRY);
      op(fmc_pkg::OP_SWAP_ACC_SERIAL);
      @(negedge mclk);
      chk(serialClockPin, 1'b0);
      $display("test shift mode done");
      op(fmc_pkg::OP_SET_CARRY);
      op(fmc_pkg::OP_CLEAR_ACC);
      op(fmc_pkg::OP_ADD_IMM, 9'h005);
      op(fmc_pkg::OP_LOAD_ENABLE, 9'h00B);
      op(fmc_pkg::OP_SWAP_ACC_SERIAL);
      chk(serialOutPin, 1'b1);
      chk(serialClockPin, 1'b1);
      @(posedge mclk) pulseGo <= 1'b1;
      @(posedge mclk) pulseGo <= 1'b0;
      // busy only shows once the peripheral has taken the start
      @(negedge mclk);
      for (int k = 0; k < 200 && pulseBusy; k++) op(fmc_pkg::OP_NOP);
      chk(pulseBusy, 1'b0);
      // last fall needs link and main sync time
      nops(24);
      op(fmc_pkg::OP_SWAP_ACC_SERIAL);
      op(fmc_pkg::OP_ACC_MEM_TO_LATCH);
      chk(lPinOut, 8'h33);
      $display("test counter mode done");
      op(fmc_pkg::OP_OUTPUT_G);
      chk(gPinOut, 4'h3);
      op(fmc_pkg::OP_NOP, 9'h133, 8'h5A, 1'b1);
      op(fmc_pkg::OP_JUMP, 9'h100);
      op(fmc_pkg::OP_LOAD_LATCH_TABLE);
      chk(lPinOut, 8'h5A);
      op(fmc_pkg::OP_JUMP_IN_PAGE, 9'h007);
      chk(progAddr, 9'h107);
      op(fmc_pkg::OP_ACC_TO_DIGIT);
      op(fmc_pkg::OP_OUTPUT_DIGIT);
      chk(digitOut, 4'h3);
      $display("test table and g port done");
      give_verdict();
   end
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end
endmodule
